// ---- hdl/mu_xfer_pkg.sv ----
package mu_xfer_pkg;

	// ****************************************
	// register map
	// ****************************************
	localparam logic [11:0] CTRL_OFF = 12'h000;
	localparam logic [11:0] MANUAL_OFF = 12'h004;
	localparam logic [11:0] STATUS_OFF = 12'h008;
	localparam logic [11:0] PROGRESS_OFF = 12'h00C;
	localparam logic [11:0] SWITCH_OFF = 12'h010;
	localparam logic [31:0] BAD_ADDR_DATA = 32'h00000000;

	// ctrl fields
	localparam int CTRL_ACK_BIT = 0;

	// manual fields
	localparam int MAN_GO_BIT = 0;
	localparam int MAN_DIR_BIT = 1;
	localparam int MAN_BANK_BIT = 2;
	localparam int MAN_TYPE_BIT = 3;
	localparam int MAN_DUAL_BIT = 4;

	// status fields
	localparam int ST_PHASE_LSB = 0;
	localparam int ST_MODE_ERR_BIT = 4;
	localparam int ST_PROT_ERR_BIT = 5;
	localparam int ST_XMIT_ERR_BIT = 6;
	localparam int ST_TYPE_ERR_BIT = 7;
	localparam int ST_DONE_BIT = 8;
	localparam int ST_BANK_BIT = 9;
	localparam int ST_DIR_BIT = 10;

	// progress fields
	localparam int PR_BLOCK_LSB = 20;

	// ****************************************
	// geometry and timing
	// ****************************************
	localparam int BLOCKS_PER_BANK = 16;
	localparam int BANK_BYTES = 1048576;
	localparam int BLOCK_BYTES = BANK_BYTES / BLOCKS_PER_BANK;
	localparam int CLK_HZ = 100000000;
	localparam int SLOW_BLINK_MS = 1000;
	localparam int FAST_BLINK_MS = 500;
	localparam int SLOW_BLINK_CYC = CLK_HZ / 1000 * SLOW_BLINK_MS;
	localparam int FAST_BLINK_CYC = CLK_HZ / 1000 * FAST_BLINK_MS;
	localparam int PREP_CYC = 16;

	typedef enum logic [2:0] {
		PH_IDLE,
		PH_PREPARE,
		PH_TRANSMIT,
		PH_VERIFY,
		PH_FINISHED,
		PH_ERROR
	} phase_t;

	typedef struct packed {
		logic auto_load_select;
		logic auto_backup_select;
		logic manual_transfer_select;
		logic data_type_select;
		logic terminal_write_enable;
		logic unit_write_enable;
		logic auto_bank_select;
		logic dual_image_enable;
	} switch_t;

	// storage-side request to the data mover
	typedef struct packed {
		logic req;
		logic to_unit;
		logic bank;
		logic system_img;
		logic [19:0] addr;
	} mover_t;

	typedef struct packed {
		logic ok;
		logic mismatch;
	} mover_rsp_t;

endpackage

// ---- hdl/memory_unit_transfer_control.sv ----
// ****************************************
// Notes on behaviour
// ****************************************
// Notes on behaviour
// - eight unit switches sampled once after reset; in manual mode the APB selection sets direction, bank, type and dual
// - three mode switches one-hot: auto load, auto backup, manual
// - no mode switch on, or several on, gives a mode error
// - data type switch off picks screen data, on picks system program
// - terminal storage written only while terminal write enable is on
// - memory unit written only while unit write enable is on
// - transfer into a write-disabled destination gives a protect error
// - auto bank switch off picks bank 0, on picks bank 1
// - dual image on ignores data type and bank switches
// - dual backup writes system to bank 0, screen to bank 1
// - dual load needs exactly one bank holding a system program
// - wrong image class into system or screen area is transmission error; dual load always takes bank 0 as system program
// - system program load refused if its terminal type differs
// - auto backup copies terminal data only while unit write enable is on
// - destination area overwritten; other bank untouched
// - backup reads terminal screen or system program storage as selected
// - phases run preparing, transmitting, verifying, finished
// - progress kept as byte count and block count, 16 blocks per bank
// - indicator blinks 1 s preparing, 0.5 s moving, steady when done; manual runs keep it dark except on an error
// - auto load copies unit data into terminal only after protect, transmission and type checks pass
// - manual mode takes direction and bank from panel selection
// - manual protect error may return to selection; others latch
//
// Implementation choices: the address map and register access over APB.
`timescale 1ns/1ns
`default_nettype none

module memory_unit_transfer_control
	import mu_xfer_pkg::*;
#(
	parameter int SLOW_CYC = SLOW_BLINK_CYC,
	parameter int FAST_CYC = FAST_BLINK_CYC,
	parameter int BANK_SIZE = BANK_BYTES
) (
	input wire logic pclk, // apb clock
	input wire logic presetn, // async reset, active low
	input wire logic clk_en, // freezes all state when low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction
	input wire logic [11:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error
	input wire switch_t unit_switches, // unit dip switches
	input wire logic [1:0] bank_has_system, // bank holds a system image
	input wire logic image_type_match, // image target type equals ours
	output mover_t mover_req, // storage copy request
	input wire mover_rsp_t mover_rsp, // storage copy answer
	output logic terminal_write_en, // terminal storage write allowed
	output logic unit_write_en, // unit write allowed
	output logic status_indicator // run indicator
);

	// ****************************************
	// state
	// ****************************************
	switch_t sw_r;
	logic sampled_r;
	phase_t phase_r, phase_nxt;
	logic [31:0] blink_cnt_r;
	logic blink_r;
	logic [20:0] byte_cnt_r;
	logic [4:0] block_cnt_r;
	// own prepare timer: the blink counter wraps too early to time it
	logic [4:0] prep_cnt_r;
	logic pass_r; // second image of a dual run
	logic mode_err_r, prot_err_r, xmit_err_r, type_err_r;
	logic man_dir_r, man_bank_r, man_type_r, man_dual_r;
	logic is_manual_r;

	logic apb_wr;
	logic to_unit, dual, sys_img, bank;
	logic prot_bad, xmit_bad;

	assign apb_wr = psel & penable & pwrite & clk_en;
	function automatic logic onehot3(input switch_t s);
		logic [1:0] n;
		n = 2'(s.auto_load_select) + 2'(s.auto_backup_select) +
			2'(s.manual_transfer_select);
		return n == 2'd1;
	endfunction

	// ****************************************
	// switch sample and decode
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sw_r <= '0;
			sampled_r <= 1'b0;
		end else if (clk_en && !sampled_r) begin
			sw_r <= unit_switches;
			sampled_r <= 1'b1;
		end
	end

	assign to_unit = sw_r.manual_transfer_select ? man_dir_r :
		sw_r.auto_backup_select;
	assign dual = sw_r.manual_transfer_select ? man_dual_r :
		sw_r.dual_image_enable;
	// dual ignores type and bank; system first into bank 0
	assign sys_img = dual ? ~pass_r :
		(sw_r.manual_transfer_select ? man_type_r : sw_r.data_type_select);
	assign bank = dual ? pass_r :
		(sw_r.manual_transfer_select ? man_bank_r : sw_r.auto_bank_select);
	assign prot_bad = to_unit ? ~sw_r.unit_write_enable :
		~sw_r.terminal_write_enable;
	// in loads the bank content must fit the target area
	always_comb begin
		xmit_bad = 1'b0;
		if (!to_unit) begin
			if (dual)
				xmit_bad = bank_has_system == 2'b00 ||
					bank_has_system == 2'b11;
			else
				xmit_bad = bank_has_system[bank] != sys_img;
		end
	end

	assign terminal_write_en = sw_r.terminal_write_enable & ~to_unit &
		(phase_r == PH_TRANSMIT);
	assign unit_write_en = sw_r.unit_write_enable & to_unit &
		(phase_r == PH_TRANSMIT);

	// ****************************************
	// phase sequence
	// ****************************************
	logic go;
	logic chunk_last;
	assign go = sw_r.manual_transfer_select ?
		(apb_wr && paddr == MANUAL_OFF && pwdata[MAN_GO_BIT]) : 1'b1;
	assign chunk_last = byte_cnt_r == 21'(BANK_SIZE - 1);

	always_comb begin
		phase_nxt = phase_r;
		case (phase_r)
			PH_IDLE: begin
				if (sampled_r) begin
					if (!onehot3(sw_r))
						phase_nxt = PH_ERROR;
					else if (go)
						phase_nxt = PH_PREPARE;
				end
			end
			PH_PREPARE: begin
				if (prot_bad || xmit_bad)
					phase_nxt = PH_ERROR;
				else if (!to_unit && sys_img && !image_type_match)
					phase_nxt = PH_ERROR;
				else if (prep_cnt_r >= 5'(PREP_CYC))
					phase_nxt = PH_TRANSMIT;
			end
			PH_TRANSMIT: begin
				if (mover_rsp.ok && chunk_last)
					phase_nxt = PH_VERIFY;
			end
			PH_VERIFY: begin
				if (mover_rsp.mismatch)
					phase_nxt = PH_ERROR;
				else if (mover_rsp.ok && chunk_last)
					phase_nxt = (dual && !pass_r) ? PH_PREPARE :
						PH_FINISHED;
			end
			PH_FINISHED: phase_nxt = PH_FINISHED;
			PH_ERROR: begin
				// only a manual protect error may be acknowledged
				if (is_manual_r && prot_err_r && !mode_err_r &&
					apb_wr && paddr == CTRL_OFF && pwdata[CTRL_ACK_BIT])
					phase_nxt = PH_IDLE;
			end
			default: phase_nxt = PH_ERROR;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			phase_r <= PH_IDLE;
		else if (clk_en)
			phase_r <= phase_nxt;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pass_r <= 1'b0;
		else if (clk_en) begin
			if (phase_r == PH_VERIFY && phase_nxt == PH_PREPARE)
				pass_r <= 1'b1;
			else if (phase_nxt == PH_IDLE)
				pass_r <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prep_cnt_r <= '0;
		else if (clk_en) begin
			if (phase_r != phase_nxt)
				prep_cnt_r <= '0;
			else if (phase_r == PH_PREPARE && prep_cnt_r != 5'(PREP_CYC))
				prep_cnt_r <= prep_cnt_r + 5'd1;
		end
	end

	// error flags latch on entry to error
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_err_r <= 1'b0;
			prot_err_r <= 1'b0;
			xmit_err_r <= 1'b0;
			type_err_r <= 1'b0;
		end else if (clk_en) begin
			if (phase_nxt == PH_IDLE && phase_r == PH_ERROR)
				prot_err_r <= 1'b0;
			else if (phase_r != PH_ERROR && phase_nxt == PH_ERROR) begin
				if (phase_r == PH_IDLE)
					mode_err_r <= 1'b1;
				else if (phase_r == PH_PREPARE && prot_bad)
					prot_err_r <= 1'b1;
				else if (phase_r == PH_PREPARE && xmit_bad)
					xmit_err_r <= 1'b1;
				else
					type_err_r <= 1'b1;
			end
		end
	end

	// ****************************************
	// data mover and progress
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			byte_cnt_r <= '0;
			block_cnt_r <= '0;
		end else if (clk_en) begin
			if (phase_r != phase_nxt) begin
				byte_cnt_r <= '0;
				block_cnt_r <= '0;
			end else if ((phase_r == PH_TRANSMIT || phase_r == PH_VERIFY) &&
				mover_rsp.ok) begin
				byte_cnt_r <= byte_cnt_r + 21'd1;
				if (byte_cnt_r[15:0] == 16'(BLOCK_BYTES - 1))
					block_cnt_r <= block_cnt_r + 5'd1;
			end
		end
	end

	// only the selected bank is addressed; backup reads terminal
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			mover_req <= '0;
		else if (clk_en) begin
			mover_req.req <= (phase_nxt == PH_TRANSMIT ||
				phase_nxt == PH_VERIFY) && phase_r == phase_nxt;
			mover_req.to_unit <= to_unit;
			mover_req.bank <= bank;
			mover_req.system_img <= sys_img;
			mover_req.addr <= byte_cnt_r[19:0];
		end
	end

	// ****************************************
	// indicator
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			blink_cnt_r <= '0;
			blink_r <= 1'b0;
		end else if (clk_en) begin
			if (phase_r != phase_nxt)
				blink_cnt_r <= '0;
			else if ((phase_r == PH_PREPARE || phase_r == PH_ERROR) ?
				blink_cnt_r >= 32'(SLOW_CYC - 1) :
				blink_cnt_r >= 32'(FAST_CYC - 1)) begin
				blink_cnt_r <= '0;
				blink_r <= ~blink_r;
			end else
				blink_cnt_r <= blink_cnt_r + 32'd1;
		end
	end

	// manual runs keep the indicator dark except on an error
	always_comb begin
		case (phase_r)
			PH_FINISHED: status_indicator = ~is_manual_r;
			PH_ERROR: status_indicator = blink_r;
			PH_PREPARE, PH_TRANSMIT, PH_VERIFY:
				status_indicator = blink_r & ~is_manual_r;
			default: status_indicator = 1'b0;
		endcase
	end

	// ****************************************
	// apb registers
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			man_dir_r <= 1'b0;
			man_bank_r <= 1'b0;
			man_type_r <= 1'b0;
			man_dual_r <= 1'b0;
			is_manual_r <= 1'b0;
		end else if (clk_en) begin
			is_manual_r <= sw_r.manual_transfer_select;
			// selection frozen once a manual run starts
			if (apb_wr && paddr == MANUAL_OFF && phase_r == PH_IDLE) begin
				man_dir_r <= pwdata[MAN_DIR_BIT];
				man_bank_r <= pwdata[MAN_BANK_BIT];
				man_type_r <= pwdata[MAN_TYPE_BIT];
				man_dual_r <= pwdata[MAN_DUAL_BIT];
			end
		end
	end

	logic addr_ok;
	assign addr_ok = paddr == CTRL_OFF || paddr == MANUAL_OFF ||
		paddr == STATUS_OFF || paddr == PROGRESS_OFF || paddr == SWITCH_OFF;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~addr_ok;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= '0;
		else if (clk_en && psel && !penable && !pwrite) begin
			case (paddr)
				MANUAL_OFF: prdata <= {27'h0, man_dual_r, man_type_r,
					man_bank_r, man_dir_r, 1'b0};
				STATUS_OFF: prdata <= {21'h0, to_unit, bank,
					phase_r == PH_FINISHED, type_err_r, xmit_err_r,
					prot_err_r, mode_err_r, 1'b0, phase_r};
				PROGRESS_OFF: prdata <= {7'h0, block_cnt_r, byte_cnt_r[19:0]};
				SWITCH_OFF: prdata <= {24'h0, sw_r};
				default: prdata <= BAD_ADDR_DATA;
			endcase
		end
	end

endmodule

`default_nettype wire

// ---- sim/mu_model.sv ----
`timescale 1ns/1ns
`default_nettype none

// ****************************************
// memory unit copy responder
// ****************************************
module mu_model
	import mu_xfer_pkg::*;
(
	input wire logic pclk, // clock
	input wire logic presetn, // reset, active low
	input wire mover_t mover_req, // copy request
	input wire logic slow, // answer every other cycle
	output mover_rsp_t mover_rsp // copy answer
);
	logic tog_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tog_r <= 1'b0;
		end else begin
			tog_r <= ~tog_r;
		end
	end

	// slow mode stretches each byte to two cycles
	assign mover_rsp.ok = mover_req.req && (!slow || tog_r);
	assign mover_rsp.mismatch = 1'b0;
endmodule

`default_nettype wire

// ---- sim/mu_xfer_monitor.sv ----
`timescale 1ns/1ns
`default_nettype none

// ****************************************
// port checker
// ****************************************
module mu_xfer_monitor
	import mu_xfer_pkg::*;
(
	input wire logic pclk, // clock
	input wire logic presetn, // reset, active low
	input wire logic clk_en, // run enable
	input wire switch_t unit_switches, // dip switches
	input wire mover_t mover_req, // copy request
	input wire logic terminal_write_en, // terminal write allowed
	input wire logic unit_write_en // unit write allowed
);
	logic first_r;
	switch_t sw_r;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// own copy of the power-up sample
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			first_r <= 1'b1;
			sw_r <= '0;
		end else if (first_r && clk_en) begin
			first_r <= 1'b0;
			sw_r <= unit_switches;
		end
	end

	AST_TERM_WE: assert property (terminal_write_en
		|-> sw_r.terminal_write_enable) else $error("terminal write");
	AST_UNIT_WE: assert property (unit_write_en
		|-> sw_r.unit_write_enable) else $error("unit write");
	AST_MODE: assert property (mover_req.req |-> $onehot({
		sw_r.auto_load_select, sw_r.auto_backup_select,
		sw_r.manual_transfer_select})) else $error("bad mode ran");
	AST_DIR: assert property (mover_req.req
		&& !sw_r.manual_transfer_select
		|-> mover_req.to_unit == sw_r.auto_backup_select)
		else $error("direction");
	AST_TYPE: assert property (mover_req.req
		&& !sw_r.manual_transfer_select && !sw_r.dual_image_enable
		|-> mover_req.system_img == sw_r.data_type_select)
		else $error("data type");
	AST_BANK: assert property (mover_req.req
		&& !sw_r.manual_transfer_select && !sw_r.dual_image_enable
		|-> mover_req.bank == sw_r.auto_bank_select) else $error("bank");
	AST_DUAL: assert property (mover_req.req
		&& sw_r.dual_image_enable && mover_req.to_unit
		|-> mover_req.bank == !mover_req.system_img)
		else $error("dual bank");
	AST_PROT: assert property (mover_req.req && mover_req.to_unit
		|-> sw_r.unit_write_enable) else $error("protect");
	AST_HOLD: assert property (mover_req.req && $past(mover_req.req)
		|-> $stable(mover_req.to_unit)) else $error("direction moved");
endmodule

bind memory_unit_transfer_control mu_xfer_monitor u_mu_xfer_monitor (
	.pclk, .presetn, .clk_en, .unit_switches, .mover_req,
	.terminal_write_en, .unit_write_en);

`default_nettype wire

// ---- sim/memory_unit_transfer_control_test.sv ----
`timescale 1ns/1ns
`default_nettype none

module memory_unit_transfer_control_test;
	import mu_xfer_pkg::*;

	// ****************************************
	// cases: switches, bank content, type match, status
	// ****************************************
	localparam int NC = 12;
	localparam logic [7:0] SWV [NC] = '{8'h00, 8'hC4, 8'h44, 8'h5E,
		8'h48, 8'h9A, 8'h94, 8'h9A, 8'h88, 8'h89, 8'h45, 8'h2C};
	localparam logic [1:0] BHS [NC] = '{2'h0, 2'h0, 2'h0, 2'h0,
		2'h0, 2'h2, 2'h2, 2'h2, 2'h1, 2'h3, 2'h0, 2'h0};
	localparam logic [31:0] EXP [NC] = '{32'h015, 32'h015, 32'h504,
		32'h704, 32'h025, 32'h304, 32'h025, 32'h085, 32'h045, 32'h045,
		32'h704, 32'h704};

	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic ind;
	switch_t sw = 8'h00;
	logic [1:0] bhs = 2'h0;
	logic match = 1'b1;
	logic slow = 1'b0;
	mover_t mreq;
	mover_rsp_t mrsp;
	int n_errors = 0;
	int samples_checked = 0;

	memory_unit_transfer_control #(.SLOW_CYC(8), .FAST_CYC(4),
		.BANK_SIZE(32)) u_memory_unit_transfer_control (
		.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .unit_switches(sw), .bank_has_system(bhs),
		.image_type_match(match), .mover_req(mreq), .mover_rsp(mrsp),
		.terminal_write_en(), .unit_write_en(), .status_indicator(ind));

	mu_model u_mu_model (.pclk(pclk), .presetn(presetn),
		.mover_req(mreq), .slow(slow), .mover_rsp(mrsp));

	initial begin
		forever #5 pclk = ~pclk;
	end

	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		logic got;
		got = 1'b0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (int i = 0; i < 16 && !got; i++) begin
			@(posedge pclk);
			got = (pready === 1'b1);
		end
		if (!got)
			n_errors++;
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial begin
		repeat (80000) @(posedge pclk);
		n_errors++;
		complete_run();
	end

	initial begin
		logic [31:0] q;
		logic [31:0] st;
		logic e;
		for (int k = 0; k < NC; k++) begin
			presetn <= 1'b0;
			sw <= SWV[k];
			bhs <= BHS[k];
			match <= (k != 7);
			slow <= k[0];
			repeat (16) @(posedge pclk);
			presetn <= 1'b1;
			repeat (3) @(posedge pclk);
			sw <= 8'h00;
			apb(1'b0, SWITCH_OFF, 32'h0, q, e);
			check(q & 32'hFF, {24'h0, SWV[k]});
			if (k == 11)
				apb(1'b1, MANUAL_OFF, 32'h7, q, e);
			st = 32'h0;
			for (int n = 0; n < 2000 && st[2:0] < 3'h4; n++)
				apb(1'b0, STATUS_OFF, 32'h0, st, e);
			// ignore bank and direction once a run has failed
			check(st & ((st[2:0] == 3'h4) ? 32'h7F7 : 32'h0F7), EXP[k]);
			if (st[2:0] == 3'h4)
				check({31'h0, ind}, {31'h0, k != 11});
			$display("test %0d done", k);
		end
		apb(1'b0, 12'h020, 32'h0, q, e);
		check(q, 32'h00000000);
		check({31'h0, e}, 32'h00000001);
		complete_run();
	end
endmodule

`default_nettype wire
